// file: hw/pwm_unit_zero_pkg.sv
package pwm_unit_zero_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_CONTROL = 6'h20;
    localparam logic [5:0] IDX_SCALER = 6'h21;
    localparam logic [5:0] IDX_DUTY_HIGH = 6'h22;
    localparam logic [5:0] IDX_DUTY_LOW = 6'h23;
    localparam logic [5:0] IDX_BOUND_HIGH = 6'h24;
    localparam logic [5:0] IDX_BOUND_LOW = 6'h25;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h30;
    localparam logic [5:0] IDX_IRQ_MASK = 6'h31;
    // control field positions
    localparam int CTL_ENABLE = 7;
    localparam int CTL_OUT_LEVEL = 6;
    localparam int CTL_INVERT = 5;
    localparam int CTL_CLEAR = 4;
    localparam int CTL_PIN_LSB = 1;
    localparam int CTL_SOURCE = 0;
    // scaler field positions
    localparam int SCL_IRQ_MODE = 7;
    localparam int SCL_PRESCALE_LSB = 5;
    localparam int SCL_DIVIDER_LSB = 0;
    // split value field positions
    localparam int BOUND_LOW_LSB = 6;
    localparam int DUTY_LOW_LSB = 5;
    // output pin routing codes
    localparam logic [2:0] PIN_NONE = 3'h0;
    localparam logic [2:0] PIN_B5 = 3'h1;
    localparam logic [2:0] PIN_A0 = 3'h3;
    localparam logic [2:0] PIN_B4 = 3'h4;
    // prescaler terminal counts for divide by 1, 4, 16, 64
    localparam logic [5:0] PRESCALE_TOP_1 = 6'h00;
    localparam logic [5:0] PRESCALE_TOP_4 = 6'h03;
    localparam logic [5:0] PRESCALE_TOP_16 = 6'h0F;
    localparam logic [5:0] PRESCALE_TOP_64 = 6'h3F;
    // reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [10:0] RESET_WORD = 11'h000;
    // interrupt status bit
    localparam int IRQ_EVENT = 0;
endpackage

// file: hw/pwm_unit_zero.sv
// Design decision made here: register access over Wishbone.
`timescale 1ns/100ps
module pwm_unit_zero #(
    parameter int OSC_DOUBLE = 0
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // fast oscillator, asynchronous
    input wire logic osc_i,
    // port pins
    output logic port_b_pin_five_o,
    output logic port_b_pin_five_oe_o,
    output logic port_a_pin_zero_o,
    output logic port_a_pin_zero_oe_o,
    output logic port_b_pin_four_o,
    output logic port_b_pin_four_oe_o,
    // interrupt
    output logic irq_o
);

    // ****************************************
    // parameter check
    // ****************************************
    if (OSC_DOUBLE < 0 || OSC_DOUBLE > 1) begin : g_bad_param
        $error("OSC_DOUBLE must be 0 or 1");
    end

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic ctl_enable;
        logic ctl_invert;
        logic ctl_clear;
        logic [2:0] ctl_pin;
        logic ctl_source;
        logic irq_mode;
        logic [1:0] prescale_sel;
        logic [4:0] divider;
        logic [9:0] bound;
        logic [2:0] duty_low;
        logic [10:0] duty;
        logic [5:0] prescale_cnt;
        logic [4:0] divide_cnt;
        logic [10:0] cnt;
        logic gen_out;
        logic [2:0] osc_sync;
        logic status;
        logic mask;
        logic irq;
        logic ack;
        logic [7:0] dat;
        logic [2:0] pin_level;
        logic [2:0] pin_oe;
    } state_s;

    state_s st;
    state_s next_st;

    function automatic logic [5:0] prescale_top(input logic [1:0] sel);
        case (sel)
            2'h0: prescale_top = pwm_unit_zero_pkg::PRESCALE_TOP_1;
            2'h1: prescale_top = pwm_unit_zero_pkg::PRESCALE_TOP_4;
            2'h2: prescale_top = pwm_unit_zero_pkg::PRESCALE_TOP_16;
            default: prescale_top = pwm_unit_zero_pkg::PRESCALE_TOP_64;
        endcase
    endfunction

    logic access;
    logic wr;
    logic [5:0] idx;
    logic osc_edge;
    logic src_tick;
    logic prescale_tick;
    logic cnt_tick;
    logic [11:0] full_bound;

    assign idx = adr_i[7:2];
    assign access = cyc_i && stb_i && !st.ack;
    assign wr = access && we_i && sel_i[0];
    assign full_bound = {1'b0, st.bound, 1'b0};

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_st = st;
        // second and third stages feed the edge detector only
        next_st.osc_sync = {st.osc_sync[1:0], osc_i};
        osc_edge = (st.osc_sync[1] && !st.osc_sync[2])
            || (OSC_DOUBLE == 1 && !st.osc_sync[1] && st.osc_sync[2]);
        src_tick = st.ctl_source ? osc_edge : 1'b1;
        prescale_tick = 1'b0;
        cnt_tick = 1'b0;
        if (st.ctl_enable && src_tick) begin
            if (st.prescale_cnt >= prescale_top(st.prescale_sel)) begin
                next_st.prescale_cnt = 6'h00;
                prescale_tick = 1'b1;
            end else begin
                next_st.prescale_cnt = st.prescale_cnt + 6'h01;
            end
        end
        if (prescale_tick) begin
            if (st.divide_cnt >= st.divider) begin
                next_st.divide_cnt = 5'h00;
                cnt_tick = 1'b1;
            end else begin
                next_st.divide_cnt = st.divide_cnt + 5'h01;
            end
        end
        if (st.ctl_clear) begin
            next_st.cnt = pwm_unit_zero_pkg::RESET_WORD;
            next_st.prescale_cnt = 6'h00;
            next_st.divide_cnt = 5'h00;
            next_st.ctl_clear = 1'b0;
        end else if (cnt_tick) begin
            if ({1'b0, st.cnt} >= full_bound) begin
                next_st.cnt = pwm_unit_zero_pkg::RESET_WORD;
            end else begin
                next_st.cnt = st.cnt + 11'h001;
            end
        end
        // bus answer
        next_st.ack = access;
        next_st.dat = pwm_unit_zero_pkg::RESET_BYTE;
        if (access && !we_i) begin
            case (idx)
                pwm_unit_zero_pkg::IDX_CONTROL: begin
                    next_st.dat[pwm_unit_zero_pkg::CTL_OUT_LEVEL] = st.gen_out;
                    next_st.dat[pwm_unit_zero_pkg::CTL_CLEAR] = st.ctl_clear;
                end
                pwm_unit_zero_pkg::IDX_IRQ_STATUS: begin
                    next_st.dat[pwm_unit_zero_pkg::IRQ_EVENT] = st.status;
                end
                pwm_unit_zero_pkg::IDX_IRQ_MASK: begin
                    next_st.dat[pwm_unit_zero_pkg::IRQ_EVENT] = st.mask;
                end
                default: begin
                    next_st.dat = pwm_unit_zero_pkg::RESET_BYTE;
                end
            endcase
        end
        if (wr) begin
            case (idx)
                pwm_unit_zero_pkg::IDX_CONTROL: begin
                    next_st.ctl_enable = dat_i[pwm_unit_zero_pkg::CTL_ENABLE];
                    next_st.ctl_invert = dat_i[pwm_unit_zero_pkg::CTL_INVERT];
                    next_st.ctl_pin = dat_i[pwm_unit_zero_pkg::CTL_PIN_LSB +: 3];
                    next_st.ctl_source = dat_i[pwm_unit_zero_pkg::CTL_SOURCE];
                    if (dat_i[pwm_unit_zero_pkg::CTL_CLEAR]) begin
                        next_st.ctl_clear = 1'b1;
                    end
                end
                pwm_unit_zero_pkg::IDX_SCALER: begin
                    next_st.irq_mode = dat_i[pwm_unit_zero_pkg::SCL_IRQ_MODE];
                    next_st.prescale_sel = dat_i[pwm_unit_zero_pkg::SCL_PRESCALE_LSB +: 2];
                    next_st.divider = dat_i[pwm_unit_zero_pkg::SCL_DIVIDER_LSB +: 5];
                end
                pwm_unit_zero_pkg::IDX_DUTY_HIGH: begin
                    next_st.duty = {dat_i[7:0], st.duty_low};
                end
                pwm_unit_zero_pkg::IDX_DUTY_LOW: begin
                    next_st.duty_low = dat_i[pwm_unit_zero_pkg::DUTY_LOW_LSB +: 3];
                end
                pwm_unit_zero_pkg::IDX_BOUND_HIGH: begin
                    next_st.bound[9:2] = dat_i[7:0];
                end
                pwm_unit_zero_pkg::IDX_BOUND_LOW: begin
                    next_st.bound[1:0] = dat_i[pwm_unit_zero_pkg::BOUND_LOW_LSB +: 2];
                end
                pwm_unit_zero_pkg::IDX_IRQ_STATUS: begin
                    if (dat_i[pwm_unit_zero_pkg::IRQ_EVENT]) begin
                        next_st.status = 1'b0;
                    end
                end
                pwm_unit_zero_pkg::IDX_IRQ_MASK: begin
                    next_st.mask = dat_i[pwm_unit_zero_pkg::IRQ_EVENT];
                end
                default: begin
                    next_st.mask = st.mask;
                end
            endcase
        end
        // event set wins over a clear in the same cycle
        if (cnt_tick && !st.ctl_clear) begin
            if (st.irq_mode ? (next_st.cnt == 11'h000) : (next_st.cnt == st.duty)) begin
                next_st.status = 1'b1;
            end
        end
        next_st.irq = next_st.status && next_st.mask;
        next_st.gen_out = next_st.ctl_enable && (next_st.cnt < next_st.duty);
        next_st.pin_level = {3{next_st.gen_out ^ next_st.ctl_invert}};
        next_st.pin_oe = {next_st.ctl_pin == pwm_unit_zero_pkg::PIN_B4,
            next_st.ctl_pin == pwm_unit_zero_pkg::PIN_A0,
            next_st.ctl_pin == pwm_unit_zero_pkg::PIN_B5};
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign dat_o = {24'h000000, st.dat};
    assign ack_o = st.ack;
    assign irq_o = st.irq;
    assign port_b_pin_five_o = st.pin_level[0];
    assign port_b_pin_five_oe_o = st.pin_oe[0];
    assign port_a_pin_zero_o = st.pin_level[1];
    assign port_a_pin_zero_oe_o = st.pin_oe[1];
    assign port_b_pin_four_o = st.pin_level[2];
    assign port_b_pin_four_oe_o = st.pin_oe[2];

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_clear_write;
        wr && idx == pwm_unit_zero_pkg::IDX_CONTROL && dat_i[pwm_unit_zero_pkg::CTL_CLEAR];
    endsequence

    sequence s_clear_done;
        st.ctl_clear ##1 (!st.ctl_clear && st.cnt == 11'h000);
    endsequence

    a_idle_count_stable: assert property (
        !st.ctl_enable && !st.ctl_clear |=> $stable(st.cnt))
        else $error("counter moved while disabled");

    a_level_read_back: assert property (
        access && !we_i && idx == pwm_unit_zero_pkg::IDX_CONTROL
        |=> ack_o && dat_o[pwm_unit_zero_pkg::CTL_OUT_LEVEL] == $past(st.gen_out))
        else $error("output level read back wrong");

    a_pin_polarity: assert property (
        st.pin_oe[0] |-> port_b_pin_five_o == (st.gen_out ^ st.ctl_invert))
        else $error("pin polarity wrong");

    a_clear_self_ends: assert property (s_clear_write |=> s_clear_done)
        else $error("counter clear did not complete");

    a_no_pin_drive: assert property (
        st.ctl_pin == pwm_unit_zero_pkg::PIN_NONE |-> st.pin_oe == 3'h0)
        else $error("pin driven with no route");

    a_source_hold: assert property (
        st.ctl_source && !osc_edge && !st.ctl_clear |=> $stable(st.prescale_cnt))
        else $error("prescaler moved without oscillator edge");

    a_irq_zero_mode: assert property (
        cnt_tick && !st.ctl_clear && st.irq_mode && next_st.cnt == 11'h000
        |=> st.status ##1 irq_o == st.mask)
        else $error("zero event not flagged");

    a_prescale_range: assert property (
        st.prescale_cnt <= prescale_top(st.prescale_sel) || $changed(st.prescale_sel)
        || $past(wr))
        else $error("prescaler beyond terminal count");

    a_divider_rate: assert property (
        prescale_tick && st.divide_cnt < st.divider |-> !cnt_tick)
        else $error("divider ticked early");

    a_count_wrap: assert property (
        cnt_tick && !st.ctl_clear && {1'b0, st.cnt} >= full_bound
        |=> st.cnt == 11'h000)
        else $error("counter did not wrap at bound");

    a_duty_latch: assert property (
        wr && idx == pwm_unit_zero_pkg::IDX_DUTY_HIGH
        |=> st.duty == {$past(dat_i[7:0]), $past(st.duty_low)})
        else $error("duty not latched");

endmodule // pwm_unit_zero

// file: test/pwm_load_model.sv
`timescale 1ns/100ps
// ****************
// pin load, pulled down when undriven
// ****************
module pwm_load_model (
    // pins from the generator
    input wire logic b5_i,
    input wire logic b5_oe_i,
    input wire logic a0_i,
    input wire logic a0_oe_i,
    input wire logic b4_i,
    input wire logic b4_oe_i,
    // resolved pin levels
    output logic b5_o,
    output logic a0_o,
    output logic b4_o
);
    assign b5_o = b5_oe_i ? b5_i : 1'h0;
    assign a0_o = a0_oe_i ? a0_i : 1'h0;
    assign b4_o = b4_oe_i ? b4_i : 1'h0;
endmodule // pwm_load_model

// file: test/pwm_unit_zero_tb_top.sv
`timescale 1ns/100ps
module pwm_unit_zero_tb_top;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o;
    logic b5, b5_oe, a0, a0_oe, b4, b4_oe, b5_lvl, a0_lvl, b4_lvl;
    logic [7:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o, rd;
    logic [2:0] oc;
    int err_total, compares, hi;
    logic [7:0] ctl_t[7] = '{8'h82, 8'hA2, 8'h82, 8'h82, 8'h82, 8'h82, 8'h83};
    logic [7:0] scl_t[7] = '{8'h00, 8'h00, 8'h21, 8'h40, 8'h60, 8'h1F, 8'h00};
    int per_t[7] = '{11, 11, 88, 176, 704, 352, 88};
    int hi_t[7] = '{5, 6, 40, 80, 320, 160, 40};
    logic [2:0] oe_t[5] = '{3'h0, 3'h4, 3'h0, 3'h2, 3'h1};

    pwm_unit_zero i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .osc_i(oc[2]), .port_b_pin_five_o(b5), .port_b_pin_five_oe_o(b5_oe),
        .port_a_pin_zero_o(a0), .port_a_pin_zero_oe_o(a0_oe), .port_b_pin_four_o(b4),
        .port_b_pin_four_oe_o(b4_oe), .irq_o(irq_o));
    pwm_load_model i_load (.b5_i(b5), .b5_oe_i(b5_oe), .a0_i(a0), .a0_oe_i(a0_oe),
        .b4_i(b4), .b4_oe_i(b4_oe), .b5_o(b5_lvl), .a0_o(a0_lvl), .b4_o(b4_lvl));

    initial begin
        clk_i = 1'h0;
        forever #2.5 clk_i = ~clk_i;
    end
    // oscillator at one eighth of the clock rate
    always @(posedge clk_i) oc <= oc + 3'h1;

    // ****************
    // tasks
    // ****************
    task automatic give_verdict;
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h000000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'h1 && n < 50);
        rd = dat_o;
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
        if (ack_o !== 1'h1) begin
            err_total++;
            give_verdict();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb(1'h1, a, d);
    endtask

    task automatic rdchk(input string name, input logic [7:0] a, input logic [7:0] exp);
        wb(1'h0, a, 8'h00);
        check(name, {24'h000000, exp}, rd);
    endtask

    task automatic measure(input logic [7:0] ctl, input logic [7:0] scl, input int per,
        input int high);
        wr(8'h84, scl);
        wr(8'h80, ctl);
        repeat (2 * per) @(posedge clk_i);
        hi = 0;
        repeat (2 * per) begin
            @(posedge clk_i);
            hi += int'(b5_lvl);
        end
        check("high count", 32'(2 * high), 32'(hi));
    endtask

    task automatic wait_irq(input logic pin);
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (irq_o !== 1'h1 && n < 2000);
        check("pin at irq", {31'h0, pin}, {31'h0, b5_lvl});
        if (irq_o !== 1'h1) begin
            err_total++;
            give_verdict();
        end
    endtask

    // ****************
    // main sequence
    // ****************
    initial begin
        rst_i = 1'h1;
        cyc_i = 1'h0;
        stb_i = 1'h0;
        we_i = 1'h0;
        adr_i = 8'h00;
        sel_i = 4'hF;
        dat_i = 32'h00000000;
        oc = 3'h0;
        err_total = 0;
        compares = 0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'h0;
        rdchk("control reset", 8'h80, 8'h00);
        rdchk("scaler read", 8'h84, 8'h00);
        rdchk("unmapped read", 8'hFC, 8'h00);
        check("irq reset", 32'h0, {31'h0, irq_o});
        wr(8'h90, 8'h01);
        wr(8'h94, 8'h7F);
        wr(8'h8C, 8'hBF);
        wr(8'h88, 8'h00);
        for (int i = 0; i < 7; i++) measure(ctl_t[i], scl_t[i], per_t[i], hi_t[i]);
        wr(8'h8C, 8'hE0);
        measure(8'h82, 8'h00, 11, 5);
        wr(8'h88, 8'h00);
        measure(8'h82, 8'h00, 11, 7);
        wr(8'h88, 8'hFF);
        rdchk("output level", 8'h80, 8'h40);
        wr(8'h80, 8'h92);
        rdchk("clear self", 8'h80, 8'h40);
        for (int i = 0; i < 5; i++) begin
            wr(8'h80, 8'h80 | {4'h0, 3'(i), 1'h0});
            repeat (2) @(posedge clk_i);
            check("pin enables", {29'h0, oe_t[i]}, {29'h0, b5_oe, a0_oe, b4_oe});
        end
        wr(8'h8C, 8'hA0);
        wr(8'h88, 8'h00);
        wr(8'h80, 8'h02);
        wr(8'hC0, 8'h01);
        wr(8'hC4, 8'h01);
        wr(8'h84, 8'h00);
        wr(8'h80, 8'h82);
        wait_irq(1'h0);
        rdchk("irq status", 8'hC0, 8'h01);
        wr(8'h80, 8'h02);
        wr(8'hC0, 8'h01);
        rdchk("status clear", 8'hC0, 8'h00);
        check("irq cleared", 32'h0, {31'h0, irq_o});
        wr(8'h84, 8'h80);
        wr(8'h80, 8'h82);
        wait_irq(1'h1);
        wr(8'h80, 8'h02);
        wr(8'hC0, 8'h01);
        wr(8'hC4, 8'h00);
        wr(8'h80, 8'h82);
        repeat (30) @(posedge clk_i);
        check("irq masked", 32'h0, {31'h0, irq_o});
        rdchk("status masked", 8'hC0, 8'h01);
        give_verdict();
    end
endmodule // pwm_unit_zero_tb_top
